// ===== forwarding_classifier.sv
// forwarding_classifier: access control redirect, learn handling and group member select
// assumes one header per valid pulse and a mac table lookup answer in the same cycle
//
// Functional notes
// - reserved address 3 frames redirect to host
// - redirected frames use configured authentication queue
// - forward only from known source addresses on ports with learn and drop bits set
// - secure mode: unknown source becomes learn frame
// - no-learning: unknown source dropped, no copy
// - group destination goes to one member
// - four bit code chooses member port
// - code is deterministic over flow fields
// - code uses mac, ip, l4, flow label
// - groups of up to sixteen members
// - group count limited only by ports
// - sixteen code-indexed masks select the member
`timescale 1ns/100ps
module forwarding_classifier (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // frame lookup
  input  wire logic                         hdr_valid_i,
  input  wire fwd_class_pkg::frame_hdr_t    hdr_i,
  input  wire fwd_class_pkg::lookup_res_t   lookup_i,
  output logic                              dec_valid_o,
  output fwd_class_pkg::fwd_decision_t      dec_o,
  // avalon-mm slave
  input  wire logic [7:0]                   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  output logic [31:0]                       avs_readdata_o,
  output logic                              avs_waitrequest_o
);
  import fwd_class_pkg::*;

  // configuration state
  logic [NUM_PORTS-1:0] reserved_addr_redirect_enable_reg;
  logic [QUEUE_W-1:0]   auth_frame_queue_select_reg;
  logic [5:0]           aggr_cfg_reg;
  logic [3:0]           port_cfg_reg [NUM_PORTS];
  logic [15:0]          port_group_mask_table_reg [NUM_CODES];
  logic [15:0]          host_cnt_reg;
  logic [15:0]          drop_cnt_reg;

  // register bus state
  bus_state_t           bus_state_reg;
  logic                 wr_hit;
  logic [31:0]          rd_value;

  // combinational datapath
  logic [CODE_W-1:0]    code;
  logic [15:0]          member_mask;
  logic                 is_auth;
  logic                 redirect;
  logic [3:0]           pcfg;
  logic                 learn_on;
  logic                 learn_cpu;
  logic                 learn_drop;
  logic                 unknown_src;
  fwd_decision_t        dec_next;

  // bus handshake: one wait cycle, answer in state done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= ST_IDLE;
    end else begin
      case (bus_state_reg)
        ST_IDLE: begin
          if (avs_read_i || avs_write_i)
            bus_state_reg <= ST_WAIT;
        end
        ST_WAIT: bus_state_reg <= ST_DONE;
        ST_DONE: bus_state_reg <= ST_IDLE;
        default: bus_state_reg <= ST_IDLE;
      endcase
    end
  end

  // waitrequest low only in the done cycle
  always_ff @(posedge clk_i) begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !(bus_state_reg == ST_WAIT);
  end

  // write takes effect at the edge the master sees waitrequest low
  assign wr_hit = avs_write_i && (bus_state_reg == ST_DONE);

  // read mux
  always_comb begin
    rd_value = UNMAPPED_READ;
    if (avs_address_i == OFS_REDIR_ENA)
      rd_value = {16'h0000, reserved_addr_redirect_enable_reg};
    else if (avs_address_i == OFS_AUTH_QUEUE)
      rd_value = {29'h00000000, auth_frame_queue_select_reg};
    else if (avs_address_i == OFS_AGGR_CFG)
      rd_value = {26'h0000000, aggr_cfg_reg};
    else if (avs_address_i == OFS_STATUS)
      rd_value = {drop_cnt_reg, host_cnt_reg};
    else if (avs_address_i[7:6] == OFS_PORT_CFG[7:6] && avs_address_i[1:0] == 2'b00)
      rd_value = {28'h0000000, port_cfg_reg[avs_address_i[5:2]]};
    else if (avs_address_i[7:6] == OFS_AGGR_MASK[7:6] && avs_address_i[1:0] == 2'b00)
      rd_value = {16'h0000, port_group_mask_table_reg[avs_address_i[5:2]]};
  end

  // read data registered with the wait state, stable in done
  always_ff @(posedge clk_i) begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (avs_read_i && bus_state_reg == ST_WAIT)
      avs_readdata_o <= rd_value;
  end

  // global configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reserved_addr_redirect_enable_reg <= REDIR_ENA_RST;
      auth_frame_queue_select_reg       <= '0;
      aggr_cfg_reg                      <= AGGR_CFG_RST;
    end else if (wr_hit) begin
      if (avs_address_i == OFS_REDIR_ENA)
        reserved_addr_redirect_enable_reg <= avs_writedata_i[15:0];
      if (avs_address_i == OFS_AUTH_QUEUE)
        auth_frame_queue_select_reg <= avs_writedata_i[QUEUE_W-1:0];
      if (avs_address_i == OFS_AGGR_CFG)
        aggr_cfg_reg <= avs_writedata_i[5:0];
    end
  end

  // per-port learn config and per-code aggregation masks
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_tab
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          port_cfg_reg[g]              <= PORT_CFG_RST;
          port_group_mask_table_reg[g] <= AGGR_MASK_RST;
        end else if (wr_hit && avs_address_i[5:2] == 4'(g) && avs_address_i[1:0] == 2'b00) begin
          if (avs_address_i[7:6] == OFS_PORT_CFG[7:6])
            port_cfg_reg[g] <= avs_writedata_i[3:0];
          if (avs_address_i[7:6] == OFS_AGGR_MASK[7:6])
            port_group_mask_table_reg[g] <= avs_writedata_i[15:0];
        end
      end
    end
  endgenerate

  // flow hash code from header fields
  flow_hash u_hash (
    .hdr_i  (hdr_i),
    .ena_i  (aggr_cfg_reg),
    .code_o (code)
  );

  // member selection by the code-indexed mask, up to 16 members
  port_select u_sel (
    .dest_mask_i (lookup_i.dest_mask),
    .is_group_i  (lookup_i.dest_is_group),
    .aggr_mask_i (port_group_mask_table_reg[code]),
    .out_mask_o  (member_mask)
  );

  // access control decision
  always_comb begin
    pcfg        = port_cfg_reg[hdr_i.src_port];
    learn_on    = pcfg[PC_LEARN];
    learn_cpu   = pcfg[PC_CPU];
    learn_drop  = pcfg[PC_DROP];
    is_auth     = (hdr_i.dmac == AUTH_DMAC);
    redirect    = is_auth && reserved_addr_redirect_enable_reg[hdr_i.src_port];
    unknown_src = learn_on && !lookup_i.smac_known;
    dec_next    = '0;
    dec_next.flow_hash_code = code;
    if (redirect) begin
      dec_next.to_host    = 1'b1;
      dec_next.host_queue = auth_frame_queue_select_reg;
    end else if (unknown_src && learn_drop) begin
      // withheld from other ports
      dec_next.fwd_mask    = '0;
      dec_next.to_host     = learn_cpu;
      dec_next.learn_frame = learn_cpu;
    end else begin
      dec_next.fwd_mask    = member_mask & ~(16'h0001 << hdr_i.src_port);
      dec_next.to_host     = unknown_src && learn_cpu;
      dec_next.learn_frame = unknown_src && learn_cpu;
    end
  end

  // registered decision output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      dec_o       <= '0;
    end else begin
      dec_valid_o <= hdr_valid_i;
      dec_o       <= hdr_valid_i ? dec_next : '0;
    end
  end

  // status counters: host-bound and discarded frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_cnt_reg <= '0;
      drop_cnt_reg <= '0;
    end else if (hdr_valid_i) begin
      if (dec_next.to_host)
        host_cnt_reg <= host_cnt_reg + 16'h0001;
      if (!dec_next.to_host && dec_next.fwd_mask == 16'h0000)
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
    end
  end
endmodule

// ===== fwd_class_pkg.sv
// fwd_class_pkg: shared constants, types and register map of the forwarding classifier
// assumes a single switch core clock domain and an avalon-mm register slave
package fwd_class_pkg;

  localparam int NUM_PORTS    = 16;
  localparam int PORT_W       = 4;
  localparam int CODE_W       = 4;
  localparam int NUM_CODES    = 16;
  localparam int QUEUE_W      = 3;
  localparam int ADDR_W       = 8;

  // reserved authentication address 01-80-C2-00-00-03
  localparam logic [47:0] AUTH_DMAC = 48'h0180C2000003;

  // register word offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_REDIR_ENA  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AUTH_QUEUE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AGGR_CFG   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG   = 8'h40;  // 16 words, one per port
  localparam logic [ADDR_W-1:0] OFS_AGGR_MASK  = 8'h80;  // 16 words, one per code

  // port_cfg field positions
  localparam int PC_LEARN = 0;
  localparam int PC_CPU   = 1;
  localparam int PC_DROP  = 2;
  localparam int PC_AUTO  = 3;

  // aggr_cfg field positions
  localparam int AG_SMAC   = 0;
  localparam int AG_DMAC   = 1;
  localparam int AG_SIPDIP = 2;
  localparam int AG_IP4L4  = 3;
  localparam int AG_IP6L4  = 4;
  localparam int AG_FLOW   = 5;

  // reset values
  localparam logic [15:0] REDIR_ENA_RST = 16'h0000;
  localparam logic [5:0]  AGGR_CFG_RST  = 6'h3F;
  localparam logic [3:0]  PORT_CFG_RST  = 4'h9;
  localparam logic [15:0] AGGR_MASK_RST = 16'hFFFF;

  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // frame header presented for one lookup
  typedef struct packed {
    logic [PORT_W-1:0] src_port;
    logic [47:0]       dmac;
    logic [47:0]       smac;
    logic              is_ip4;
    logic              is_ip6;
    logic              has_l4;
    logic [31:0]       sip;
    logic [31:0]       dip;
    logic [15:0]       sport;
    logic [15:0]       dport;
    logic [19:0]       flow_label;
  } frame_hdr_t;

  // table lookup answer from the mac table
  typedef struct packed {
    logic              smac_known;
    logic [NUM_PORTS-1:0] dest_mask;
    logic              dest_is_group;
  } lookup_res_t;

  // forwarding decision
  typedef struct packed {
    logic [NUM_PORTS-1:0] fwd_mask;
    logic                 to_host;
    logic                 learn_frame;
    logic [QUEUE_W-1:0]   host_queue;
    logic [CODE_W-1:0]    flow_hash_code;
  } fwd_decision_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } bus_state_t;

endpackage

// ===== flow_hash.sv
// flow_hash: folds the enabled header fields into the 4-bit flow hash code
// assumes a registered header; pure combinational fold
`timescale 1ns/100ps
module flow_hash (
  input  wire fwd_class_pkg::frame_hdr_t hdr_i,
  input  wire logic [5:0]                ena_i,
  output logic [3:0]                     code_o
);
  import fwd_class_pkg::*;

  // disabled field contributes zero, flow fields only
  logic [191:0] fields;
  always_comb begin
    fields = '0;
    if (ena_i[AG_SMAC])
      fields[47:0] = hdr_i.smac;
    if (ena_i[AG_DMAC])
      fields[95:48] = hdr_i.dmac;
    if (ena_i[AG_SIPDIP] && hdr_i.is_ip4)
      fields[159:96] = {hdr_i.sip, hdr_i.dip};
    if (((ena_i[AG_IP4L4] && hdr_i.is_ip4) || (ena_i[AG_IP6L4] && hdr_i.is_ip6)) && hdr_i.has_l4)
      fields[191:160] = {hdr_i.sport, hdr_i.dport};
    if (ena_i[AG_FLOW] && hdr_i.is_ip6)
      fields[179:160] = fields[179:160] ^ hdr_i.flow_label;
  end

  // xor fold in nibbles
  always_comb begin
    code_o = '0;
    for (int i = 0; i < 48; i++) begin
      code_o = code_o ^ fields[i*4 +: 4];
    end
  end
endmodule

// ===== port_select.sv
// port_select: narrows a group destination to a single member by aggregation mask
// assumes software keeps masks one-hot inside each group
`timescale 1ns/100ps
module port_select (
  input  wire logic [15:0] dest_mask_i,
  input  wire logic        is_group_i,
  input  wire logic [15:0] aggr_mask_i,
  output logic [15:0]      out_mask_o
);
  // apply the selected mask only for group destinations
  assign out_mask_o = is_group_i ? (dest_mask_i & aggr_mask_i) : dest_mask_i;
endmodule

// ===== fwd_class_asserts.sv
// fwd_class_asserts: port-level checks of lookup timing, forwarding and bus answer
// assumes it is bound to forwarding_classifier and sees only its ports
`timescale 1ns/100ps
module fwd_class_asserts (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         hdr_valid_i,
  input wire fwd_class_pkg::frame_hdr_t    hdr_i,
  input wire fwd_class_pkg::lookup_res_t   lookup_i,
  input wire logic                         dec_valid_o,
  input wire fwd_class_pkg::fwd_decision_t dec_o,
  input wire logic                         avs_read_i,
  input wire logic                         avs_write_i,
  input wire logic                         avs_waitrequest_o
);
  import fwd_class_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a new request, then two waiting edges and the answer
  sequence bus_req;
    (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i);
  endsequence
  sequence bus_answer;
    avs_waitrequest_o [*2] ##1 !avs_waitrequest_o;
  endsequence
  a_bus_answer_time: assert property (bus_req |-> bus_answer)
    else $error("bus answer not at second edge after request");
  a_bus_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_dec_latency: assert property (hdr_valid_i |=> dec_valid_o)
    else $error("decision late");
  a_dec_quiet: assert property (!hdr_valid_i |=> !dec_valid_o && dec_o == '0)
    else $error("decision without header");
  a_group_one_port: assert property (hdr_valid_i && lookup_i.dest_is_group |=> $onehot0(dec_o.fwd_mask))
    else $error("group frame on several ports");
  a_mask_within_dest: assert property (hdr_valid_i |=> (dec_o.fwd_mask & ~$past(lookup_i.dest_mask)) == 16'h0000)
    else $error("forward outside destination");
  a_known_unicast: assert property (hdr_valid_i && lookup_i.smac_known && !lookup_i.dest_is_group
    && hdr_i.dmac != AUTH_DMAC |=> dec_o.fwd_mask == ($past(lookup_i.dest_mask)
    & ~(16'h0001 << $past(hdr_i.src_port))))
    else $error("known unicast mask wrong");
  a_known_no_learn: assert property (hdr_valid_i && lookup_i.smac_known |=> !dec_o.learn_frame)
    else $error("learn frame from known source");
  a_auth_no_fwd: assert property (hdr_valid_i && lookup_i.smac_known && hdr_i.dmac == AUTH_DMAC
    |=> !(dec_o.to_host && dec_o.fwd_mask != 16'h0000))
    else $error("redirected frame also forwarded");
  a_code_stable: assert property ((hdr_valid_i && !(avs_write_i && !avs_waitrequest_o)) ##1
    (hdr_valid_i && $stable(hdr_i)) |=> $stable(dec_o.flow_hash_code))
    else $error("same flow gave another code");
endmodule
bind forwarding_classifier fwd_class_asserts sva (.clk_i(clk_i), .rst_i(rst_i), .hdr_valid_i(hdr_valid_i),
  .hdr_i(hdr_i), .lookup_i(lookup_i), .dec_valid_o(dec_valid_o), .dec_o(dec_o), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o));

// ===== mac_table_model.sv
// mac_table_model: behavioural mac table answering each header lookup in the same cycle
// assumes the bench stands in for host software inserting authenticated stations
`timescale 1ns/100ps
module mac_table_model #(
  parameter logic [47:0] GROUP_DMAC = 48'h0000000000AA
) (
  input  wire logic                      clk_i,
  input  wire logic                      ins_i,
  input  wire logic [47:0]               ins_smac_i,
  input  wire fwd_class_pkg::frame_hdr_t hdr_i,
  output fwd_class_pkg::lookup_res_t     lookup_o
);
  import fwd_class_pkg::*;
  logic [3:0][47:0] known_mem;
  logic [2:0]       known_cnt = 3'd0;
  logic             hit;
  // host software inserts a station once it is authenticated, four at most
  always @(posedge clk_i) begin
    if (ins_i) begin
      known_mem[known_cnt[1:0]] <= ins_smac_i;
      known_cnt <= known_cnt + 3'd1;
    end
  end
  // prefix 02 stations are preloaded; the group of same-speed ports 0,1,4,5 is the only group
  always_comb begin
    hit = (hdr_i.smac[47:40] == 8'h02);
    for (int i = 0; i < 4; i++)
      if (3'(i) < known_cnt && known_mem[i] == hdr_i.smac)
        hit = 1'b1;
    lookup_o.smac_known    = hit;
    lookup_o.dest_is_group = (hdr_i.dmac == GROUP_DMAC);
    lookup_o.dest_mask     = lookup_o.dest_is_group ? 16'h0033 : 16'h0001 << hdr_i.dmac[3:0];
  end
endmodule

// ===== testbench.sv
// testbench: register setup over avalon-mm and frame lookups with expected decisions
// assumes the classifier, its package, the mac table model and the checker
`timescale 1ns/100ps
module testbench;
  import fwd_class_pkg::*;
  localparam logic [47:0] GROUP_DMAC = 48'h0000000000AA;
  localparam logic [47:0] DA = 48'h123456789AB1;
  localparam logic [47:0] SA = 48'h02000000F0E5;
  logic          clk_i = 0, rst_i = 1, hdr_valid = 0, rd = 0, wr = 0, ins = 0, dec_valid, waitreq;
  logic [7:0]    addr = 0;
  logic [31:0]   wdata = 0, rdata, got;
  logic [47:0]   ins_smac = 0;
  frame_hdr_t    hdr = '0;
  frame_hdr_t    ext = '0;
  lookup_res_t   lk;
  fwd_decision_t dec;
  int            fail_count = 0, cmp_count = 0;
  // 25 MHz core clock
  always #20 clk_i = ~clk_i;
  mac_table_model #(.GROUP_DMAC(GROUP_DMAC)) partner (.clk_i(clk_i), .ins_i(ins), .ins_smac_i(ins_smac),
    .hdr_i(hdr), .lookup_o(lk));
  forwarding_classifier dut (.clk_i(clk_i), .rst_i(rst_i), .hdr_valid_i(hdr_valid), .hdr_i(hdr), .lookup_i(lk),
    .dec_valid_o(dec_valid), .dec_o(dec), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one avalon-mm word transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk_i);
    while (waitreq !== 1'b0) @(posedge clk_i);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  // header held n cycles; the last decision is left on dec
  task frame(input logic [3:0] sp, input logic [47:0] da, input logic [47:0] sa, input int n);
    frame_hdr_t h;
    h = ext;
    h.src_port = sp;
    h.dmac = da;
    h.smac = sa;
    @(posedge clk_i);
    hdr <= h;
    hdr_valid <= 1'b1;
    repeat (n) @(posedge clk_i);
    hdr_valid <= 1'b0;
    #1;
    chk(32'(dec_valid), 32'h1);
  endtask
  task dec_chk(input logic [15:0] fwd, input logic host);
    chk(32'(dec.fwd_mask), 32'(fwd));
    chk(32'(dec.to_host), 32'(host));
  endtask
  function automatic logic [3:0] fold(input logic [47:0] v);
    fold = 4'h0;
    for (int i = 0; i < 12; i++) fold ^= v[i*4 +: 4];
  endfunction
  function automatic int mem(input int c);
    return {c[1], 1'b0, c[0]};
  endfunction
  // watchdog
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_REDIR_ENA, 32'(REDIR_ENA_RST));
    rd_chk(OFS_AUTH_QUEUE, 32'h0);
    rd_chk(OFS_AGGR_CFG, 32'(AGGR_CFG_RST));
    rd_chk(OFS_PORT_CFG, 32'(PORT_CFG_RST));
    rd_chk(OFS_AGGR_MASK + 8'h3C, 32'(AGGR_MASK_RST));
    bus(1'b1, 8'h30, 32'h0000FFFF);
    rd_chk(8'h30, UNMAPPED_READ);
    // redirect on enabled port only, to the chosen queue
    bus(1'b1, OFS_REDIR_ENA, 32'h00000084);
    bus(1'b1, OFS_AUTH_QUEUE, 32'h5);
    frame(4'd7, AUTH_DMAC, 48'h020000000001, 1);
    dec_chk(16'h0000, 1'b1);
    chk(32'(dec.host_queue), 32'h5);
    frame(4'd4, AUTH_DMAC, 48'h020000000001, 1);
    dec_chk(16'h0008, 1'b0);
    // secure learning: unknown source becomes learn frame until inserted
    bus(1'b1, OFS_PORT_CFG + 8'h18, 32'h7);
    frame(4'd6, 48'h1, 48'h0A0000000006, 1);
    dec_chk(16'h0000, 1'b1);
    chk(32'(dec.learn_frame), 32'h1);
    @(posedge clk_i);
    ins <= 1'b1;
    ins_smac <= 48'h0A0000000006;
    @(posedge clk_i);
    ins <= 1'b0;
    frame(4'd6, 48'h1, 48'h0A0000000006, 1);
    dec_chk(16'h0002, 1'b0);
    // no learning: unknown source dropped, authentication still reaches host
    bus(1'b1, OFS_PORT_CFG + 8'h1C, 32'h5);
    frame(4'd7, 48'h1, 48'h0B0000000007, 1);
    dec_chk(16'h0000, 1'b0);
    frame(4'd7, AUTH_DMAC, 48'h0B0000000007, 1);
    dec_chk(16'h0000, 1'b1);
    // code from no field, source mac only, destination mac only
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, OFS_AGGR_CFG, k == 0 ? 32'h0 : 32'h1 << (k - 1));
      frame(4'd8, DA, SA, 1);
      chk(32'(dec.flow_hash_code), k == 0 ? 32'h0 : 32'(fold(k == 1 ? SA : DA)));
    end
    // ip fields: v4 addresses, v4 ports, then v6 ports with flow label
    ext.is_ip4 = 1'b1;
    ext.has_l4 = 1'b1;
    ext.sip = 32'h0A000001;
    ext.dip = 32'h0A000002;
    ext.sport = 16'h1234;
    ext.dport = 16'h0050;
    ext.flow_label = 20'h00007;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) ext.is_ip4 = 1'b0;
      if (k == 2) ext.is_ip6 = 1'b1;
      bus(1'b1, OFS_AGGR_CFG, k == 0 ? 32'h4 : k == 1 ? 32'h8 : 32'h30);
      frame(4'd8, DA, SA, 1);
      chk(32'(dec.flow_hash_code), k == 0 ? 32'h3 : k == 1 ? 32'h1 : 32'h6);
    end
    ext = '0;
    // group on ports 0,1,4,5 spread by code, each flow held two cycles
    bus(1'b1, OFS_AGGR_CFG, 32'h1);
    for (int c = 0; c < 16; c++) bus(1'b1, OFS_AGGR_MASK + 8'(4 * c), 32'hFFCC | (32'h1 << mem(c)));
    for (int c = 0; c < 16; c++) begin
      frame(4'd8, GROUP_DMAC, {8'h02, 36'h0, 4'(c) ^ 4'h2}, 2);
      chk(32'(dec.flow_hash_code), 32'(c));
      chk(32'(dec.fwd_mask), 32'h1 << mem(c));
    end
    // one dropped frame and three host-bound frames were sent
    rd_chk(OFS_STATUS, 32'h00010003);
    end_of_test();
  end
endmodule
